// >>> src/rsc_clk_if.sv
/*
 rsc_clk_if: carries the clock-activity sample and the missing-clock timeout between
 top and detector. assumes both ends run on ref_clk.
*/
`timescale 1ns/10ps
interface rsc_clk_if;
    logic clk_seen; // one when the watched core clock toggled
    logic enable; // detector armed
    logic timeout; // clock missing too long
    modport top
    (
        output clk_seen,
        output enable,
        input timeout
    );
    modport det
    (
        input clk_seen,
        input enable,
        output timeout
    );
endinterface : rsc_clk_if

// >>> src/rsc_consts.svh
/*
 reset source controller constants: register offsets, bit positions, reset values, timings.
 assumes it is included by bare name from design files and from the testbench.
*/
`ifndef RSC_CONSTS_SVH
`define RSC_CONSTS_SVH
// register offsets on the plain register port
`define RSC_ADDR_SRC 4'h0
`define RSC_ADDR_MON 4'h1
`define RSC_ADDR_PSC 4'h2
`define RSC_ADDR_WDT 4'h3
`define RSC_ADDR_LOCK 4'h4
// reset source register bit positions
`define RSC_BIT_PIN 0
`define RSC_BIT_POR 1
`define RSC_BIT_MCD 2
`define RSC_BIT_CMP 5
`define RSC_BIT_WDT 4
`define RSC_BIT_FERR 6
`define RSC_BIT_SWRST 4
// monitor register bit positions
`define RSC_BIT_MEN 7
`define RSC_BIT_MLVL 5
// program store control bit
`define RSC_BIT_PWE 0
// watchdog: update command and disable bits in its register
`define RSC_BIT_WDKICK 0
`define RSC_BIT_WDDIS 1
// timing
`define RSC_MCD_US 100
`define RSC_CLK_MHZ 100
`define RSC_MCD_CYC (`RSC_MCD_US * `RSC_CLK_MHZ)
`define RSC_WDT_DIV 12
`define RSC_REL_DLY 8'h20
`define RSC_ZERO8 8'h00
`endif

// >>> src/rsc_mcd.sv
/*
 rsc_mcd: missing clock counter; timeout stays high until an edge or disarm.
 assumes the top reports each core clock edge it observes, sampled on ref_clk.
*/
`timescale 1ns/10ps
`include "rsc_consts.svh"
module rsc_mcd
#(
    parameter int LIMIT = `RSC_MCD_CYC
)
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    rsc_clk_if.det bus
);
    import rsc_pkg::*;
    typedef struct packed
    {
        logic [15:0] cnt; // cycles since last edge
        logic to; // timeout flag
    } rsc_mcd_state_t;
    rsc_mcd_state_t st;
    rsc_mcd_state_t next_st;
    // restart on every observed edge, time out past the limit
    always_comb
    begin
        next_st = st;
        next_st.to = 1'b0;
        if (!bus.enable || bus.clk_seen)
        begin
            next_st.cnt = 16'h0000;
        end
        else if (st.cnt >= 16'(LIMIT - 1))
        begin
            next_st.to = 1'b1; // R1
        end
        else
        begin
            next_st.cnt = st.cnt + 16'h0001;
        end
    end
    // state register
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            st <= '0;
        else
            st <= next_st;
    end
    assign bus.timeout = st.to;
    AST_MCD_FIRES: assert property (@(posedge ref_clk) disable iff (sys_rst) // R1
        (bus.timeout |-> $past(bus.enable)))
        else $error("missing clock timeout while detector off");
endmodule : rsc_mcd

// >>> src/rsc_pkg.sv
/*
 reset source controller package: types shared by top and its detector.
 assumes rsc_consts.svh is on the include path.
*/
package rsc_pkg;
    // reset sequencing states
    typedef enum logic [1:0]
    {
        RSC_RUN = 2'b00,
        RSC_HOLD = 2'b01,
        RSC_DELAY = 2'b10
    } rsc_phase_t;
    // cause flags latched at reset entry
    typedef struct packed
    {
        logic ferr;
        logic cmp;
        logic wdt;
        logic mcd;
        logic por;
        logic pin;
    } rsc_cause_t;
endpackage : rsc_pkg

// >>> src/rsc_top.sv
/*
 rsc_top: reset source controller; merges supply, pin, clock, comparator, watchdog
 and flash error sources into a core reset and keeps the cause flags.
 assumes sys_rst is the power-on reset and the core_clock is a pin to be watched.
*/
// How it works
// (R1) clock stuck over 100 us resets
// (R2) missing_clock_flag bit 2 shows clock cause
// (R3) writing bit 2 arms or disarms detector
// (R4) internal resets leave reset pin alone
// (R5) low pin resets; pin flag bit 0
// (R6) bit 5 arms comparator reset source
// (R7) comparator_reset_flag shows comparator cause
// (R8) watchdog enabled after reset, clock/12
// (R9) watchdog expiry resets, sets its flag
// (R10) low supply drives pin, holds core
// (R11) power-on alone enables standard monitor
// (R12) level monitor always a source
// (R13) flash write needs monitor high, enabled
// (R14) software enables monitor before selecting
// (R15) software writes power_on_flag one always
// (R16) supply reset skips release delay
// (R17) illegal flash access causes error reset
// (R18) flash_error_flag bit 6 after error
// (R19) write enable redirects move writes
// (R20) hold while source active, sync release
`timescale 1ns/10ps
`include "rsc_consts.svh"
module rsc_top
#(
    parameter int MCD_LIMIT = `RSC_MCD_CYC,
    parameter logic [15:0] WDT_LOAD = 16'hffff,
    parameter logic [15:0] LOCK_DEFAULT = 16'h1dff
)
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic core_clock,
    input wire logic rst_pin_n_in,
    output logic rst_pin_out,
    output logic rst_pin_oe,
    input wire logic supply_low_std,
    input wire logic supply_low_lvl,
    input wire logic comparator_zero,
    input wire logic flash_wr_req,
    input wire logic [15:0] flash_addr,
    input wire logic code_fetch,
    input wire logic [15:0] code_addr,
    input wire logic security_block,
    input wire logic ext_move_wr,
    output logic move_to_flash,
    output logic core_rst
);
    import rsc_pkg::*;
    typedef struct packed
    {
        logic [2:0] pin_s; // pin synchroniser
        logic [2:0] clk_s; // core clock synchroniser
        logic [2:0] cmp_s; // comparator synchroniser
        logic [2:0] sup_s; // supply synchroniser
        logic pin_lvl; // filtered pin level (low active)
        logic clk_lvl; // filtered core clock
        logic cmp_lvl; // filtered comparator, one = below
        logic sup_lvl; // filtered supply low
        rsc_phase_t phase; // sequencer
        logic [7:0] dly; // release delay counter
        rsc_cause_t cause; // latched cause flags
        logic std_en; // standard monitor enabled
        logic std_sel; // standard monitor selected as source
        logic lvl_hi; // monitor level select
        logic mcd_en; // detector armed
        logic cmp_en; // comparator source armed
        logic pwe; // program write enable
        logic wd_en; // watchdog running
        logic [3:0] wd_pre; // divide by twelve
        logic [15:0] wd_cnt; // watchdog downcount
        logic [15:0] lock; // lock byte address
        logic [7:0] rdata; // read data
        logic rst_out; // pin drive
        logic core_rst; // core held
        logic mtf; // move redirect
    } rsc_state_t;
    rsc_state_t st;
    rsc_state_t next_st;
    rsc_clk_if cif();
    logic src_any; // any enabled source active now
    rsc_cause_t now; // which source is active now
    logic supply_trip; // supply below threshold
    logic ferr_now; // flash error condition
    logic [7:0] src_rd; // reset source register image
    // missing clock detector
    rsc_mcd #(.LIMIT(MCD_LIMIT)) u_mcd
    (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .bus(cif.det)
    );
    assign cif.clk_seen = st.clk_lvl != st.clk_s[2] || st.clk_s[1] != st.clk_s[2];
    assign cif.enable = st.mcd_en && st.phase == RSC_RUN;
    // source decode
    always_comb
    begin
        supply_trip = st.sup_lvl; // R12
        ferr_now = 1'b0;
        if (flash_wr_req && (!st.std_en || !st.std_sel || !st.lvl_hi))
            ferr_now = 1'b1; // R13
        if (flash_wr_req && st.pwe && flash_addr > st.lock)
            ferr_now = 1'b1; // R17
        if (code_fetch && code_addr > st.lock)
            ferr_now = 1'b1; // R17
        if (security_block)
            ferr_now = 1'b1; // R17
        now = '0;
        now.pin = !st.pin_lvl; // R5
        now.mcd = cif.timeout; // R1
        now.cmp = st.cmp_en && st.cmp_lvl; // R6
        now.wdt = st.wd_en && st.wd_cnt == 16'h0000 && st.wd_pre == 4'h0; // R9
        now.ferr = ferr_now && st.phase == RSC_RUN;
        now.por = supply_trip;
        src_any = |now; // R20
        src_rd = `RSC_ZERO8;
        src_rd[`RSC_BIT_PIN] = st.cause.pin;
        src_rd[`RSC_BIT_POR] = st.cause.por;
        src_rd[`RSC_BIT_MCD] = st.cause.mcd; // R2
        src_rd[`RSC_BIT_WDT] = st.cause.wdt;
        src_rd[`RSC_BIT_CMP] = st.cause.cmp; // R7
        src_rd[`RSC_BIT_FERR] = st.cause.ferr; // R18
    end
    // next state
    always_comb
    begin
        next_st = st;
        next_st.pin_s = {st.pin_s[1:0], rst_pin_n_in};
        next_st.clk_s = {st.clk_s[1:0], core_clock};
        next_st.cmp_s = {st.cmp_s[1:0], comparator_zero};
        // the standard monitor trips only while it is both enabled and selected
        next_st.sup_s = {st.sup_s[1:0],
            supply_low_lvl || (supply_low_std && st.std_en && st.std_sel)}; // R11 R12
        if (st.pin_s[1] == st.pin_s[2])
            next_st.pin_lvl = st.pin_s[2];
        if (st.clk_s[1] == st.clk_s[2])
            next_st.clk_lvl = st.clk_s[2];
        if (st.cmp_s[1] == st.cmp_s[2])
            next_st.cmp_lvl = st.cmp_s[2];
        if (st.sup_s[1] == st.sup_s[2])
            next_st.sup_lvl = st.sup_s[2];
        next_st.rdata = `RSC_ZERO8;
        // watchdog prescale by twelve
        if (st.wd_en && st.phase == RSC_RUN)
        begin
            if (st.wd_pre == 4'(`RSC_WDT_DIV - 1))
            begin
                next_st.wd_pre = 4'h0; // R8
                if (st.wd_cnt != 16'h0000)
                    next_st.wd_cnt = st.wd_cnt - 16'h0001;
            end
            else
            begin
                next_st.wd_pre = st.wd_pre + 4'h1;
            end
        end
        // register reads
        if (reg_rd)
        begin
            unique case (reg_addr)
                `RSC_ADDR_SRC: next_st.rdata = src_rd;
                `RSC_ADDR_MON:
                begin
                    next_st.rdata[`RSC_BIT_MEN] = st.std_en;
                    next_st.rdata[`RSC_BIT_MLVL] = st.lvl_hi;
                end
                `RSC_ADDR_PSC: next_st.rdata[`RSC_BIT_PWE] = st.pwe;
                `RSC_ADDR_WDT: next_st.rdata[`RSC_BIT_WDDIS] = !st.wd_en;
                `RSC_ADDR_LOCK: next_st.rdata = st.lock[15:8];
                default: next_st.rdata = `RSC_ZERO8;
            endcase
        end
        // register writes
        if (reg_wr)
        begin
            unique case (reg_addr)
                `RSC_ADDR_SRC:
                begin
                    next_st.std_sel = reg_wdata[`RSC_BIT_POR];
                    next_st.mcd_en = reg_wdata[`RSC_BIT_MCD]; // R3
                    next_st.cmp_en = reg_wdata[`RSC_BIT_CMP]; // R6
                end
                `RSC_ADDR_MON:
                begin
                    next_st.std_en = reg_wdata[`RSC_BIT_MEN];
                    next_st.lvl_hi = reg_wdata[`RSC_BIT_MLVL];
                end
                `RSC_ADDR_PSC: next_st.pwe = reg_wdata[`RSC_BIT_PWE];
                `RSC_ADDR_WDT:
                begin
                    if (reg_wdata[`RSC_BIT_WDKICK])
                        next_st.wd_cnt = WDT_LOAD;
                    next_st.wd_en = !reg_wdata[`RSC_BIT_WDDIS];
                end
                `RSC_ADDR_LOCK: next_st.lock = {reg_wdata, 8'hff};
                default: next_st.lock = st.lock;
            endcase
        end
        // sequencer
        unique case (st.phase)
            RSC_RUN:
            begin
                if (src_any)
                begin
                    next_st.phase = RSC_HOLD;
                    next_st.cause = now;
                end
            end
            RSC_HOLD:
            begin
                if (src_any)
                begin
                    // keep pin and supply causes seen earlier in this hold, so a supply
                    // reset that drags the pin low still skips the release delay
                    next_st.cause = now;
                    next_st.cause.pin = now.pin || st.cause.pin;
                    next_st.cause.por = now.por || st.cause.por; // R16
                end
                else if (st.cause.por)
                begin
                    next_st.phase = RSC_RUN; // R16
                end
                else
                begin
                    next_st.phase = RSC_DELAY;
                    next_st.dly = `RSC_REL_DLY;
                end
            end
            RSC_DELAY:
            begin
                if (src_any)
                    next_st.phase = RSC_HOLD;
                else if (st.dly == 8'h00)
                    next_st.phase = RSC_RUN;
                else
                    next_st.dly = st.dly - 8'h01;
            end
            default: next_st.phase = RSC_HOLD;
        endcase
        // any reset re-arms the watchdog and keeps the level monitor
        if (st.phase != RSC_RUN)
        begin
            next_st.wd_en = 1'b1; // R8
            next_st.wd_pre = 4'h0;
            next_st.wd_cnt = WDT_LOAD;
            next_st.pwe = 1'b0;
            next_st.mcd_en = 1'b0;
            next_st.cmp_en = 1'b0;
        end
        next_st.rst_out = st.sup_lvl; // R10 R4
        next_st.core_rst = next_st.phase != RSC_RUN; // R20
        next_st.mtf = st.pwe && ext_move_wr; // R19
    end
    // state register; power-on turns the standard monitor on and selects it
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st <= '0;
            st.pin_s <= 3'h7;
            st.pin_lvl <= 1'b1;
            st.phase <= RSC_HOLD;
            st.cause <= 6'h02; // power-on cause
            st.std_en <= 1'b1; // R11
            st.std_sel <= 1'b1; // R11
            st.wd_en <= 1'b1;
            st.wd_cnt <= WDT_LOAD;
            st.lock <= LOCK_DEFAULT;
            st.core_rst <= 1'b1;
        end
        else
        begin
            st <= next_st;
        end
    end
    assign reg_rdata = st.rdata;
    assign rst_pin_out = 1'b0;
    assign rst_pin_oe = st.rst_out;
    assign core_rst = st.core_rst;
    assign move_to_flash = st.mtf;
    AST_CORE_HELD: assert property (@(posedge ref_clk) disable iff (sys_rst) // R20
        (src_any |=> core_rst))
        else $error("core not held while source active");
    AST_PIN_FLAG: assert property (@(posedge ref_clk) disable iff (sys_rst) // R5
        (st.phase == RSC_RUN && !st.pin_lvl |=> st.cause.pin))
        else $error("pin cause not recorded");
    AST_SUPPLY_NODELAY: assert property (@(posedge ref_clk) disable iff (sys_rst) // R16
        (st.phase == RSC_HOLD && !src_any && st.cause.por |=> st.phase == RSC_RUN))
        else $error("supply reset took delay");
    AST_INT_NO_PIN: assert property (@(posedge ref_clk) disable iff (sys_rst) // R4
        (!st.sup_lvl |=> !rst_pin_oe))
        else $error("internal reset drove pin");
    AST_FERR: assert property (@(posedge ref_clk) disable iff (sys_rst) // R13
        (st.phase == RSC_RUN && flash_wr_req && !st.lvl_hi |=> st.cause.ferr))
        else $error("flash error not taken");
    AST_MOVE: assert property (@(posedge ref_clk) disable iff (sys_rst) // R19
        (move_to_flash |-> $past(st.pwe) && $past(ext_move_wr)))
        else $error("move redirect without enable");
    AST_WDT_RUN: assert property (@(posedge ref_clk) disable iff (sys_rst) // R8
        (st.phase == RSC_DELAY |=> st.wd_en))
        else $error("watchdog not enabled after reset");
    AST_CMP: assert property (@(posedge ref_clk) disable iff (sys_rst) // R7
        (st.phase == RSC_RUN && now == 6'h10 |=> src_rd[`RSC_BIT_CMP] && !src_rd[`RSC_BIT_MCD]))
        else $error("comparator cause wrong");
endmodule : rsc_top

// >>> tb/reset_source_controller_tb.sv
/*
 reset_source_controller_tb: drives rsc_top through its register port and reset sources.
 assumes rsc_partner stands in for the reset button and the watched core clock.
*/
`timescale 1ns/10ps
`include "rsc_consts.svh"
module reset_source_controller_tb;
    logic ref_clk, sys_rst, reg_wr, reg_rd, rd_q; // clock, reset, strobes
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    logic core_clock, rst_pin_n_in, rst_pin_out, rst_pin_oe, pin_req, clk_run;
    logic supply_low_std, supply_low_lvl, comparator_zero, flash_wr_req, code_fetch;
    logic security_block, ext_move_wr, move_to_flash, core_rst;
    logic [15:0] flash_addr, code_addr, seed;
    logic [7:0] expq[$]; // expected read data, oldest first
    int failures, check_count, n, k;
    // short counts keep the run brief
    rsc_top #(.MCD_LIMIT(50), .WDT_LOAD(16'h0010)) dut
    (
        .ref_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .core_clock, .rst_pin_n_in, .rst_pin_out, .rst_pin_oe, .supply_low_std,
        .supply_low_lvl, .comparator_zero, .flash_wr_req, .flash_addr, .code_fetch,
        .code_addr, .security_block, .ext_move_wr, .move_to_flash, .core_rst
    );
    rsc_partner far_end
    (
        .pin_req, .clk_run, .rst_pin_out, .rst_pin_oe, .rst_pin_n_in, .core_clock
    );
    // free-running system clock
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    function automatic logic [15:0] xs();
        logic [15:0] s;
        s = seed;
        s ^= s << 7;
        s ^= s >> 9;
        s ^= s << 8;
        return s;
    endfunction : xs
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic results();
        if (failures == 0 && check_count > 0)
        begin
            $display("TEST PASSED");
        end
        else
        begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : results
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr
    // read strobe; the expected byte waits in the queue for the watcher
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        expq.push_back(e);
        @(posedge ref_clk);
        reg_rd <= 1'b0;
    endtask : rd
    // bounded wait for the core reset level; n holds the cycles spent
    task automatic wait_rst(input logic v, input int lim);
        n = 0;
        while (core_rst !== v && n < lim)
        begin
            @(posedge ref_clk);
            n++;
        end
        if (core_rst !== v)
        begin
            failures++;
            results();
        end
    endtask : wait_rst
    // wait for release, then park the watchdog so later steps are not cut short
    task automatic up();
        wait_rst(1'b0, 300);
        wr(`RSC_ADDR_WDT, 8'h02);
    endtask : up
    // watcher: read data stand only in the cycle after the strobe
    always @(posedge ref_clk)
    begin
        rd_q <= reg_rd;
    end
    always @(negedge ref_clk)
    begin
        if (rd_q === 1'b1 && expq.size() > 0)
        begin
            chk(reg_rdata, expq.pop_front());
        end
    end
    // main sequence: one reset cause after another
    initial
    begin
        sys_rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        pin_req = 1'b0;
        clk_run = 1'b1;
        supply_low_std = 1'b0;
        supply_low_lvl = 1'b0;
        comparator_zero = 1'b0;
        flash_wr_req = 1'b0;
        code_fetch = 1'b0;
        security_block = 1'b0;
        ext_move_wr = 1'b0;
        flash_addr = 16'h0000;
        code_addr = 16'h0000;
        seed = 16'h0010;
        failures = 0;
        check_count = 0;
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        wait_rst(1'b0, 100);
        chk({7'h0, n < 20}, 8'h01);
        rd(`RSC_ADDR_SRC, 8'h02);
        rd(`RSC_ADDR_MON, 8'h80);
        rd(4'hf, 8'h00);
        wr(`RSC_ADDR_WDT, 8'h01);
        wait_rst(1'b1, 260);
        chk({7'h0, n > 180}, 8'h01);
        chk({7'h0, rst_pin_oe}, 8'h00);
        up();
        rd(`RSC_ADDR_SRC, 8'h10);
        pin_req <= 1'b1;
        wait_rst(1'b1, 20);
        pin_req <= 1'b0;
        up();
        chk({7'h0, n > 31}, 8'h01);
        rd(`RSC_ADDR_SRC, 8'h01);
        wr(`RSC_ADDR_SRC, 8'h02);
        clk_run <= 1'b0;
        repeat (120) @(posedge ref_clk);
        chk({7'h0, core_rst}, 8'h00);
        wr(`RSC_ADDR_SRC, 8'h06);
        wait_rst(1'b1, 80);
        clk_run <= 1'b1;
        up();
        rd(`RSC_ADDR_SRC, 8'h04);
        comparator_zero <= 1'b1;
        repeat (20) @(posedge ref_clk);
        chk({7'h0, core_rst}, 8'h00);
        wr(`RSC_ADDR_SRC, 8'h22);
        wait_rst(1'b1, 20);
        comparator_zero <= 1'b0;
        up();
        rd(`RSC_ADDR_SRC, 8'h20);
        supply_low_lvl <= 1'b1;
        wait_rst(1'b1, 20);
        repeat (4) @(posedge ref_clk);
        chk({7'h0, rst_pin_oe}, 8'h01);
        supply_low_lvl <= 1'b0;
        up();
        chk({7'h0, n < 20}, 8'h01);
        // standard monitor: ignored while deselected, resets once selected while low
        wr(`RSC_ADDR_SRC, 8'h00);
        supply_low_std <= 1'b1;
        repeat (10) @(posedge ref_clk);
        chk({7'h0, core_rst}, 8'h00);
        wr(`RSC_ADDR_SRC, 8'h02);
        wait_rst(1'b1, 20);
        supply_low_std <= 1'b0;
        up();
        chk({7'h0, n < 20}, 8'h01);
        wr(`RSC_ADDR_MON, 8'ha0);
        wr(`RSC_ADDR_SRC, 8'h02);
        // legal access, low monitor level, fetch above lock, security block
        for (k = 0; k < 4; k++)
        begin
            seed = xs();
            if (k == 1)
            begin
                wr(`RSC_ADDR_MON, 8'h80);
            end
            @(posedge ref_clk);
            flash_addr <= seed & 16'h0fff;
            code_addr <= (k == 2) ? (16'h1e00 | seed) : (seed & 16'h0fff);
            flash_wr_req <= (k < 2);
            code_fetch <= (k != 1);
            security_block <= (k == 3);
            @(posedge ref_clk);
            flash_wr_req <= 1'b0;
            code_fetch <= 1'b0;
            security_block <= 1'b0;
            if (k == 0)
            begin
                repeat (10) @(posedge ref_clk);
                chk({7'h0, core_rst}, 8'h00);
            end
            else
            begin
                wait_rst(1'b1, 20);
                up();
                rd(`RSC_ADDR_SRC, 8'h40);
            end
        end
        wr(`RSC_ADDR_PSC, 8'h01);
        @(posedge ref_clk);
        ext_move_wr <= 1'b1;
        @(posedge ref_clk);
        ext_move_wr <= 1'b0;
        @(negedge ref_clk);
        chk({7'h0, move_to_flash}, 8'h01);
        // flash write above the lock with write enable set and a legal monitor setup
        wr(`RSC_ADDR_MON, 8'ha0);
        seed = xs();
        @(posedge ref_clk);
        flash_addr <= seed | 16'he000;
        flash_wr_req <= 1'b1;
        @(posedge ref_clk);
        flash_wr_req <= 1'b0;
        wait_rst(1'b1, 20);
        up();
        rd(`RSC_ADDR_SRC, 8'h40);
        repeat (4) @(posedge ref_clk);
        results();
    end
endmodule : reset_source_controller_tb

// >>> tb/rsc_partner.sv
/*
 rsc_partner: external reset circuitry and core clock source beside rsc_top.
 assumes the bench asks for button presses and clock stops; the pin has a pull-up.
*/
`timescale 1ns/10ps
module rsc_partner
(
    input wire logic pin_req,
    input wire logic clk_run,
    input wire logic rst_pin_out,
    input wire logic rst_pin_oe,
    output logic rst_pin_n_in,
    output logic core_clock
);
    // watched clock, unrelated in phase to ref_clk; stands still when stopped
    initial
    begin
        core_clock = 1'b0;
        forever
        begin
            #7;
            if (clk_run)
            begin
                core_clock = ~core_clock;
            end
        end
    end
    // wire level: device drive wins, else the button pulls low, else the pull-up
    always_comb
    begin
        if (rst_pin_oe)
        begin
            rst_pin_n_in = rst_pin_out;
        end
        else
        begin
            rst_pin_n_in = ~pin_req;
        end
    end
endmodule : rsc_partner
